// [pkg/ddps_regs.vh]
// Register constants for the dual data pointer select block.
// Assumes inclusion by bare name from the design file.
`ifndef DDPS_REGS_VH
`define DDPS_REGS_VH
// ========================================
// Register map
`define DDPS_AUX_ADDR 8'hA2
`define DDPS_PTR_FIRST_LO_ADDR 8'h82
`define DDPS_PTR_FIRST_HI_ADDR 8'h83
// ========================================
// Field positions
`define DDPS_SEL_BIT 0
`define DDPS_ZERO_BIT 2
`define DDPS_FLAG_BIT 3
`define DDPS_BOOT_BIT 5
// ========================================
// Reset values and boot window
`define DDPS_SEL_RST 1'h0
`define DDPS_FLAG_RST 1'h0
`define DDPS_BOOT_RST 1'h0
`define DDPS_RDATA_RST 8'h00
`define DDPS_HIT_RST 1'h0
`define DDPS_PTR_RST 16'h0000
`define DDPS_BOOT_BASE 16'hF800
`endif

// [verilog/ddps_dual_pointer.v]
// Dual 16-bit data pointer pair with auxiliary select/control register.
// Assumes the core drives a one-cycle SFR write or increment strobe on sys_clk_i.
`timescale 1ns/1ns
`default_nettype none
`include "ddps_regs.vh"

// Contract
// RULE1: Two independent 16-bit pointers, either may address external data.
// RULE2: Accesses and pointer operations use the pointer the select bit designates.
// RULE3: Select bit 0 clear picks first pointer, set picks second.
// RULE4: Boot enable bit 5 maps boot memory at F800h to FFFFh when set.
// RULE5: Bit 2 reads zero, ignores writes, so increment toggles select only.
// RULE6: Incrementing the register inverts select, never forces it.
// RULE7: Software never writes ones to reserved bits 7, 6, 4, 1.
// RULE8: Reset clears select and bit 2; other bits have a plain reset.
// RULE9: User flag bit 3 stores writes, reads back, drives nothing.
module ddps_dual_pointer
(
  input wire sys_clk_i,
  input wire arst_n_i,
  input wire [7:0] sfr_addr_i,
  input wire [7:0] sfr_wdata_i,
  input wire sfr_wr_i,
  input wire sfr_inc_i,
  input wire ptr_inc_i,
  input wire [15:0] xaddr_i,
  output reg [7:0] sfr_rdata_o,
  output reg sfr_hit_o,
  output reg [15:0] ptr_addr_o,
  output reg pointer_select_o,
  output reg boot_hit_o
);

  // ========================================
  // State, next values and decode results
  wire [31:0] ptr_bank;
  wire [15:0] pointer_first;
  wire [15:0] pointer_second;
  wire aux_hit;
  wire ptr_lo_hit;
  wire ptr_hi_hit;
  reg pointer_select_reg;
  reg pointer_select_next;
  reg boot_map_enable_reg;
  reg boot_map_enable_next;
  reg user_flag_bit_reg;
  reg user_flag_bit_next;
  reg [7:0] aux_now;
  reg [7:0] aux_sum;
  reg [7:0] aux_image_next;
  reg [15:0] ptr_sel;
  reg [15:0] ptr_addr_next;
  reg [7:0] rdata_next;
  reg sfr_hit_next;
  reg boot_hit_next;
  genvar g;

  // ========================================
  // Address decode and register image
  function is_aux_addr;
    input [7:0] addr;
    begin
      is_aux_addr = (addr == `DDPS_AUX_ADDR);
    end
  endfunction

  function is_ptr_lo_addr;
    input [7:0] addr;
    begin
      is_ptr_lo_addr = (addr == `DDPS_PTR_FIRST_LO_ADDR);
    end
  endfunction

  function is_ptr_hi_addr;
    input [7:0] addr;
    begin
      is_ptr_hi_addr = (addr == `DDPS_PTR_FIRST_HI_ADDR);
    end
  endfunction

  // Reserved bits and bit 2 always read back as zero
  function [7:0] aux_image;
    input sel;
    input flag;
    input boot;
    begin
      aux_image = 8'h00;
      aux_image[`DDPS_SEL_BIT] = sel;
      aux_image[`DDPS_FLAG_BIT] = flag;
      aux_image[`DDPS_BOOT_BIT] = boot;
      aux_image[`DDPS_ZERO_BIT] = 1'b0; // RULE5
    end
  endfunction

  assign aux_hit = is_aux_addr(sfr_addr_i);
  assign ptr_lo_hit = is_ptr_lo_addr(sfr_addr_i);
  assign ptr_hi_hit = is_ptr_hi_addr(sfr_addr_i);

  // ========================================
  // Auxiliary register next state
  always @*
  begin
    aux_now = aux_image(pointer_select_reg, user_flag_bit_reg, boot_map_enable_reg);
    // Bit 1 held at zero stops the carry at bit 1, so the flag stays put
    aux_sum = aux_now + 8'h01; // RULE6
    pointer_select_next = pointer_select_reg;
    user_flag_bit_next = user_flag_bit_reg;
    boot_map_enable_next = boot_map_enable_reg;
    if (aux_hit && sfr_wr_i)
    begin
      pointer_select_next = sfr_wdata_i[`DDPS_SEL_BIT]; // RULE3
      user_flag_bit_next = sfr_wdata_i[`DDPS_FLAG_BIT]; // RULE9
      boot_map_enable_next = sfr_wdata_i[`DDPS_BOOT_BIT];
    end
    else if (aux_hit && sfr_inc_i)
    begin
      pointer_select_next = aux_sum[`DDPS_SEL_BIT]; // RULE6
      user_flag_bit_next = aux_sum[`DDPS_FLAG_BIT];
      boot_map_enable_next = aux_sum[`DDPS_BOOT_BIT];
    end
    aux_image_next = aux_image(pointer_select_next, user_flag_bit_next, boot_map_enable_next); // RULE5
  end

  always @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pointer_select_reg <= `DDPS_SEL_RST; // RULE8
      boot_map_enable_reg <= `DDPS_BOOT_RST;
      user_flag_bit_reg <= `DDPS_FLAG_RST;
    end
    else
    begin
      pointer_select_reg <= pointer_select_next; // RULE6
      boot_map_enable_reg <= boot_map_enable_next;
      user_flag_bit_reg <= user_flag_bit_next; // RULE9
    end
  end

  // ========================================
  // Pointer pair, one slot per pointer; only the selected slot moves
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : gen_ptr
      reg [15:0] pointer_reg;
      reg [15:0] pointer_next;
      wire slot_active;

      assign slot_active = (g == 1) ? pointer_select_reg : ~pointer_select_reg;

      always @*
      begin
        pointer_next = pointer_reg;
        if (slot_active) // RULE2
        begin
          if (sfr_wr_i && ptr_lo_hit)
            pointer_next = {pointer_reg[15:8], sfr_wdata_i};
          else if (sfr_wr_i && ptr_hi_hit)
            pointer_next = {sfr_wdata_i, pointer_reg[7:0]};
          else if (ptr_inc_i)
            pointer_next = pointer_reg + 16'h0001; // RULE1
        end
      end

      always @(posedge sys_clk_i or negedge arst_n_i)
      begin
        if (!arst_n_i)
          pointer_reg <= `DDPS_PTR_RST;
        else
          pointer_reg <= pointer_next;
      end

      assign ptr_bank[16 * g +: 16] = pointer_reg;
    end
  endgenerate

  assign pointer_first = ptr_bank[15:0];
  assign pointer_second = ptr_bank[31:16];

  // ========================================
  // Pointer views for reads and for the address output
  always @*
  begin
    ptr_sel = pointer_select_reg ? pointer_second : pointer_first; // RULE3
  end

  always @*
  begin
    ptr_addr_next = pointer_select_next ? pointer_second : pointer_first; // RULE2
  end

  // ========================================
  // Read path and output next values
  always @*
  begin
    rdata_next = `DDPS_RDATA_RST;
    if (aux_hit)
      rdata_next = aux_image_next; // RULE9
    else if (ptr_lo_hit)
      rdata_next = ptr_sel[7:0];
    else if (ptr_hi_hit)
      rdata_next = ptr_sel[15:8];
  end

  always @*
  begin
    sfr_hit_next = aux_hit || ptr_lo_hit || ptr_hi_hit;
    boot_hit_next = boot_map_enable_next && (xaddr_i >= `DDPS_BOOT_BASE); // RULE4
  end

  // ========================================
  // Registered outputs
  always @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sfr_rdata_o <= `DDPS_RDATA_RST;
      sfr_hit_o <= `DDPS_HIT_RST;
      ptr_addr_o <= `DDPS_PTR_RST;
      pointer_select_o <= `DDPS_SEL_RST; // RULE8
      boot_hit_o <= `DDPS_HIT_RST;
    end
    else
    begin
      sfr_rdata_o <= rdata_next;
      sfr_hit_o <= sfr_hit_next;
      ptr_addr_o <= ptr_addr_next; // RULE2
      pointer_select_o <= pointer_select_next;
      boot_hit_o <= boot_hit_next; // RULE4
    end
  end

endmodule
`default_nettype wire

// [verification/ddps_dual_pointer_monitor.sv]
// Checker for the dual pointer block.
// Assumes it sees the top module's ports only.
`timescale 1ns/1ns
`default_nettype none
module ddps_dual_pointer_monitor
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_inc_i,
  input wire logic ptr_inc_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic [15:0] xaddr_i,
  input wire logic [15:0] ptr_addr_o,
  input wire logic sfr_hit_o,
  input wire logic pointer_select_o,
  input wire logic boot_hit_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic aw;
  assign aw = sfr_wr_i && sfr_addr_i == 8'hA2;
  // ========================================
  // Properties
  inc_toggle_a: assert property (sfr_inc_i && !sfr_wr_i && sfr_addr_i == 8'hA2
    |=> pointer_select_o != $past(pointer_select_o)) else $error("increment did not toggle");
  wr_sel_a: assert property (aw |=> pointer_select_o == $past(sfr_wdata_i[0]))
    else $error("select write lost");
  zero_bit_a: assert property (aw |=> !sfr_rdata_o[2]) else $error("bit 2 not zero");
  user_flag_a: assert property (aw |=> sfr_rdata_o[3] == $past(sfr_wdata_i[3]))
    else $error("flag not stored");
  boot_map_a: assert property (aw |=> boot_hit_o == ($past(sfr_wdata_i[5]) && $past(xaddr_i) >= 16'hF800))
    else $error("boot window wrong");
  sel_hold_a: assert property (!sfr_wr_i && !sfr_inc_i |=> $stable(pointer_select_o))
    else $error("select moved");
  ptr_map_a: assert property (sfr_addr_i == 8'h82 || sfr_addr_i == 8'h83 |=> sfr_hit_o)
    else $error("pointer byte unmapped");
  reset_val_a: assert property (disable iff (1'b0) !arst_n_i |=> !pointer_select_o && !boot_hit_o
    && sfr_rdata_o == 8'h00 && ptr_addr_o == 16'h0000 && !sfr_hit_o) else $error("reset value wrong");
  ptr_step_a: assert property ((ptr_inc_i && !sfr_wr_i && !sfr_inc_i) ##1 (!sfr_wr_i && !sfr_inc_i)
    |=> ptr_addr_o == $past(ptr_addr_o) + 16'h0001) else $error("pointer step lost");
endmodule
bind ddps_dual_pointer ddps_dual_pointer_monitor mon (.sys_clk_i, .arst_n_i, .sfr_wr_i, .sfr_inc_i, .ptr_inc_i,
  .sfr_addr_i, .sfr_wdata_i, .sfr_rdata_o, .xaddr_i, .ptr_addr_o, .sfr_hit_o, .pointer_select_o, .boot_hit_o);
`default_nettype wire

// [verification/ddps_core_model.sv]
// Core model issuing one-cycle register strobes.
// Assumes the block samples on the rising edge.
`timescale 1ns/1ns
`default_nettype none
module ddps_core_model
(
  input wire logic clk_i,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic inc_o,
  output logic pinc_o
);
  initial {addr_o, wdata_o, wr_o, inc_o, pinc_o} = 19'h00000;
  // One-cycle step of the selected pointer
  task step;
    @(negedge clk_i);
    pinc_o = 1'b1;
    @(negedge clk_i);
    pinc_o = 1'b0;
  endtask
  task op(input logic [7:0] a, d, input logic w, i);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = (a == 8'hA2) ? (d & 8'h2D) : d;
    wr_o = w;
    inc_o = i;
    @(negedge clk_i);
    wr_o = 1'b0;
    inc_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// [verification/dual_data_pointer_select_tb.sv]
// Testbench for the dual pointer block.
// Assumes the core model drives the register strobes.
`timescale 1ns/1ns
`default_nettype none
module dual_data_pointer_select_tb;
  logic clk = 1'b0, rst_n = 1'b0;
  logic [15:0] xa = 16'hF800;
  wire [7:0] a, d, rd;
  wire w, i, pi, hit, sel, bh;
  wire [15:0] pa;
  int errors = 0, checks_done = 0;
  always #5 clk = ~clk;
  ddps_core_model core (.clk_i(clk), .addr_o(a), .wdata_o(d), .wr_o(w), .inc_o(i), .pinc_o(pi));
  ddps_dual_pointer uut (.sys_clk_i(clk), .arst_n_i(rst_n), .sfr_addr_i(a), .sfr_wdata_i(d), .sfr_wr_i(w),
    .sfr_inc_i(i), .ptr_inc_i(pi), .xaddr_i(xa), .sfr_rdata_o(rd), .sfr_hit_o(hit), .ptr_addr_o(pa),
    .pointer_select_o(sel), .boot_hit_o(bh));
  task chk(input logic [15:0] got, exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ========================================
  // Scenarios
  task t_fields;
    core.op(8'hA2, 8'h00, 1'b0, 1'b0);
    chk({rd & 8'h05, 7'h00, sel}, 16'h0000);
    core.op(8'hA2, 8'hFF, 1'b1, 1'b0);
    chk({rd, 6'h00, sel, bh}, 16'h2903);
    xa = 16'hF7FF;
    core.op(8'hA2, 8'h20, 1'b1, 1'b0);
    chk({rd, 6'h00, sel, bh}, 16'h2000);
    xa = 16'hFFFF;
    core.op(8'hA2, 8'h00, 1'b0, 1'b0);
    chk({rd, 6'h00, sel, bh}, 16'h2001);
    xa = 16'hF7FF;
    core.op(8'hA2, 8'h08, 1'b1, 1'b0);
    chk({rd, 6'h00, sel, bh}, 16'h0800);
    $display("fields done");
  endtask
  task t_inc;
    core.op(8'hA2, 8'h00, 1'b0, 1'b1);
    chk({rd, 7'h00, sel}, 16'h0901);
    core.op(8'hA2, 8'h00, 1'b0, 1'b1);
    chk({rd, 7'h00, sel}, 16'h0800);
    $display("inc done");
  endtask
  task t_ptr;
    core.op(8'h82, 8'h34, 1'b1, 1'b0);
    core.op(8'h83, 8'h12, 1'b1, 1'b0);
    core.op(8'hA2, 8'h01, 1'b1, 1'b0);
    chk(pa, 16'h0000);
    core.op(8'h82, 8'h78, 1'b1, 1'b0);
    core.op(8'hA2, 8'h00, 1'b1, 1'b0);
    chk(pa, 16'h1234);
    core.op(8'hA2, 8'h00, 1'b0, 1'b1);
    chk(pa, 16'h0078);
    $display("ptr done");
  endtask
  task t_step;
    core.step();
    core.op(8'h82, 8'h00, 1'b0, 1'b0);
    chk(pa, 16'h0079);
    chk({rd, 7'h00, hit}, 16'h7901);
    core.op(8'hA2, 8'h00, 1'b0, 1'b1);
    core.step();
    core.op(8'h83, 8'h00, 1'b0, 1'b0);
    chk(pa, 16'h1235);
    chk({rd, 7'h00, hit}, 16'h1201);
    $display("step done");
  endtask
  initial
  begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    t_fields();
    t_inc();
    t_ptr();
    t_step();
    print_verdict();
  end
  initial
  begin
    #5000;
    errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
